// [design/tse_pkg.sv]
// Shared constants for the trigger sequence engine.
package tse_pkg;
  // Build-time sizes.
  localparam int NUM_TERMS      = 16;
  localparam int TERM_IDX_W     = 4;
  localparam int SLOTS          = 4;
  localparam int SLOT_W         = 8;
  localparam int MAX_STAGES_DEF = 16;
  localparam int CNT_W_DEF      = 16;
  localparam int EVT_LIMIT_DEF  = 65535;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DEPTH    = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_STAGE    = 8'h40;
  localparam logic [7:0] STAGE_STRIDE = 8'h08;
  localparam logic [7:0] OFS_CFG_SUB  = 8'h04;
  // Control bits, write one to act.
  localparam int CTRL_ARM    = 0;
  localparam int CTRL_DISARM = 1;
  // Status bits.
  localparam int ST_RUN  = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR  = 2;
  localparam int ST_PTR  = 4;
  // Interrupt bits.
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_REJ  = 1;
  localparam int IRQ_W    = 2;
  // Slot fields inside a stage condition word.
  localparam int SL_TERM = 0;
  localparam int SL_NEG  = 4;
  localparam int SL_OP   = 5;
  localparam int SL_GRP  = 7;
  // Stage configuration fields.
  localparam int CF_CNT  = 0;
  localparam int CF_MODE = 16;
  localparam int CF_IMM  = 18;
  localparam int CF_TRUE = 19;
  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  RST_MASK = 2'h0;
  // Slot combine operators.
  typedef enum logic [1:0] {OP_AND, OP_OR, OP_XOR, OP_NONE} tse_op_e;
  // Occurrence counter modes.
  typedef enum logic [1:0] {CM_NONE, CM_ANY, CM_CONSEC, CM_BAD} tse_cm_e;
  // Sequencer states.
  typedef enum logic [1:0] {SQ_IDLE, SQ_RUN, SQ_DONE} tse_sq_e;
endpackage

// [design/tse_trigger_sequence_engine.sv]
// Trigger sequencer with its Wishbone register file and interrupt.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - Up to sixteen ordered stages per expression.
// - Immediate link checks next stage one cycle only.
// - Immediate stage false then restart from first.
// - Eventual link waits, checking from next cycle.
// - Any-order counter counts true cycles to target.
// - Consecutive counter break restarts whole expression.
// - Count limit fixed at build, not software.
// - Always-true stage with count is a delay.
// - One counter per stage, whole condition.
// - Immediate-entered stage forbids any-order counter.
// - Group first, else left to right in stage.
// - Negation tighter; binary operators share precedence.
// - Single term stage triggers on that match.
// - Reserved depth is build time, may exceed loaded.
// - Depth above reserved is rejected, never run.
// - Grouping never crosses a stage boundary.
module tse_trigger_sequence_engine #(
  parameter int MAX_STAGES = tse_pkg::MAX_STAGES_DEF,
  parameter int CNT_W      = tse_pkg::CNT_W_DEF,
  parameter int EVT_LIMIT  = tse_pkg::EVT_LIMIT_DEF
) (
  // Clock and reset.
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  // Wishbone slave.
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [7:0]                     wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  // Match term results, one bit per term.
  input  wire logic [tse_pkg::NUM_TERMS-1:0]  matchTerm,
  // Trigger and interrupt.
  output logic                                trigger,
  output logic                                irq
);
  import tse_pkg::*;
  localparam int PW = $clog2(MAX_STAGES);
  localparam int DW = $clog2(MAX_STAGES + 1);
  localparam logic [DW-1:0]    MAXD  = DW'(MAX_STAGES);
  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(EVT_LIMIT);
  // Storage for the loaded expression; reserved depth is fixed here.
  logic [31:0]    condMem [MAX_STAGES];
  logic [31:0]    cfgMem  [MAX_STAGES];
  logic [DW-1:0]  depthReg;
  logic [IRQ_W-1:0] irqStatReg;
  logic [IRQ_W-1:0] irqMaskReg;
  logic           errReg;
  logic           ackReg;
  logic [31:0]    datReg;
  tse_sq_e        stateReg;
  logic [PW-1:0]  ptrReg;
  logic [CNT_W-1:0] cntReg;
  logic           firstReg;
  logic           trigReg;
  // Bus decode; a write lands on the edge where ack is seen high.
  logic       wbReq;
  logic       wbWr;
  logic       stageHit;
  logic [PW-1:0] stageIdx;
  logic       cfgSel;
  logic [31:0] selMask;
  assign wbReq    = wb_cyc_i & wb_stb_i;
  assign wbWr     = wbReq & wb_we_i & ackReg;
  assign stageHit = (wb_adr_i >= OFS_STAGE) &&
                    (wb_adr_i < OFS_STAGE + 8'(MAX_STAGES * 8));
  assign stageIdx = PW'((wb_adr_i - OFS_STAGE) >> 3);
  assign cfgSel   = wb_adr_i[2];
  assign selMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction
  logic armPulse;
  logic disarmPulse;
  assign armPulse    = wbWr && wb_adr_i == OFS_CTRL &&
                       wb_sel_i[0] && wb_dat_i[CTRL_ARM];
  assign disarmPulse = wbWr && wb_adr_i == OFS_CTRL &&
                       wb_sel_i[0] && wb_dat_i[CTRL_DISARM];
  // Ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= wbReq & ~ackReg;
    end
  end
  assign wb_ack_o = ackReg;
  // Stage memory writes; arrays have no reset, software loads them.
  always_ff @(posedge core_clk) begin
    if (wbWr && stageHit) begin
      if (cfgSel) begin
        cfgMem[stageIdx] <= merge(cfgMem[stageIdx], wb_dat_i, selMask);
      end else begin
        condMem[stageIdx] <= merge(condMem[stageIdx], wb_dat_i, selMask);
      end
    end
  end
  // Loaded depth and interrupt mask.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      depthReg   <= DW'(1);
      irqMaskReg <= RST_MASK;
    end else if (wbWr && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_DEPTH) begin
        depthReg <= wb_dat_i[DW-1:0];
      end
      if (wb_adr_i == OFS_IRQ_MASK) begin
        irqMaskReg <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end
  // Condition of one stage: negation per slot, then a left-to-right
  // fold where a run of group-flagged slots folds first.
  function automatic logic evalCond(input logic [31:0] w,
                                    input logic [NUM_TERMS-1:0] t);
    logic outer;
    logic inner;
    logic v;
    logic inGrp;
    logic first;
    logic [1:0] gop;
    logic [SLOT_W-1:0] s;
    outer = 1'b0;
    inner = 1'b0;
    inGrp = 1'b0;
    first = 1'b1;
    gop   = OP_AND;
    for (int k = 0; k < SLOTS; k++) begin
      s = w[k*SLOT_W +: SLOT_W];
      v = t[s[SL_TERM +: TERM_IDX_W]] ^ s[SL_NEG];
      if (k == 0 || s[SL_OP +: 2] != OP_NONE) begin
        if (s[SL_GRP]) begin
          if (!inGrp) begin
            inner = v;
            gop   = s[SL_OP +: 2];
            inGrp = 1'b1;
          end else begin
            inner = comb(inner, v, s[SL_OP +: 2]);
          end
        end else begin
          if (inGrp) begin
            outer = first ? inner : comb(outer, inner, gop);
            first = 1'b0;
            inGrp = 1'b0;
          end
          outer = first ? v : comb(outer, v, s[SL_OP +: 2]);
          first = 1'b0;
        end
      end
    end
    // A group still open is closed at the end of its own stage.
    if (inGrp) begin
      outer = first ? inner : comb(outer, inner, gop);
    end
    evalCond = outer;
  endfunction

  function automatic logic comb(input logic a, input logic b,
                                input logic [1:0] op);
    unique case (op)
      OP_AND:  comb = a & b;
      OP_OR:   comb = a | b;
      OP_XOR:  comb = a ^ b;
      OP_NONE: comb = a;
    endcase
  endfunction
  // Arm-time check over the loaded stages.
  logic cfgValid;
  always_comb begin
    cfgValid = depthReg != '0 && depthReg <= MAXD;
    for (int i = 0; i < MAX_STAGES; i++) begin
      if (DW'(i) < depthReg) begin
        if (cfgMem[i][CF_MODE +: 2] == CM_BAD) begin
          cfgValid = 1'b0;
        end
        if (cfgMem[i][CF_CNT +: CNT_W] > LIMIT) begin
          cfgValid = 1'b0;
        end
        if (cfgMem[i][CF_IMM] && i != 0 &&
            cfgMem[i][CF_MODE +: 2] == CM_ANY) begin
          cfgValid = 1'b0;
        end
      end
    end
  end
  // Current stage view.
  logic [31:0]      curCfg;
  logic             cond;
  logic [1:0]       mode;
  logic             immEntry;
  logic [CNT_W-1:0] target;
  logic [CNT_W-1:0] cntInc;
  logic             lastStage;
  logic             hit;
  logic             restart;
  assign curCfg    = cfgMem[ptrReg];
  // The counter field is the only one per stage and covers it whole.
  assign mode      = curCfg[CF_MODE +: 2];
  assign cond      = curCfg[CF_TRUE] | evalCond(condMem[ptrReg],
                                                matchTerm);
  assign immEntry  = curCfg[CF_IMM] && ptrReg != '0 && firstReg;
  assign target    = (curCfg[CF_CNT +: CNT_W] == '0) ? CNT_W'(1)
                                                  : curCfg[CF_CNT +: CNT_W];
  assign cntInc    = cntReg + CNT_W'(1);
  assign lastStage = DW'(ptrReg) + DW'(1) >= depthReg;
  // Completion and abandonment decisions for the current cycle.
  always_comb begin
    hit     = 1'b0;
    restart = 1'b0;
    if (stateReg == SQ_RUN) begin
      if (immEntry && !cond) begin
        restart = 1'b1;
      end else if (mode == CM_NONE) begin
        hit = cond;
      end else if (cond) begin
        hit = cntInc >= target;
      end else if (mode == CM_CONSEC && cntReg != '0) begin
        restart = 1'b1;
      end
    end
  end
  // Sequencer state, pointer and occurrence counter.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stateReg <= SQ_IDLE;
      ptrReg   <= '0;
      cntReg   <= '0;
      firstReg <= 1'b0;
    end else if (armPulse) begin
      // An invalid expression never leaves idle.
      stateReg <= cfgValid ? SQ_RUN : SQ_IDLE;
      ptrReg   <= '0;
      cntReg   <= '0;
      firstReg <= 1'b0;
    end else if (disarmPulse) begin
      stateReg <= SQ_IDLE;
    end else if (stateReg == SQ_RUN) begin
      firstReg <= 1'b0;
      if (restart) begin
        ptrReg <= '0;
        cntReg <= '0;
      end else if (hit) begin
        cntReg <= '0;
        if (lastStage) begin
          stateReg <= SQ_DONE;
        end else begin
          ptrReg   <= ptrReg + PW'(1);
          firstReg <= 1'b1;
        end
      end else if (cond && mode != CM_NONE) begin
        cntReg <= cntInc;
      end
    end
  end
  // Single-cycle trigger pulse on final completion.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trigReg <= 1'b0;
    end else begin
      trigReg <= hit && lastStage && !armPulse && !disarmPulse;
    end
  end
  assign trigger = trigReg;
  // Error flag from the last arm attempt.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      errReg <= 1'b0;
    end else if (armPulse) begin
      errReg <= !cfgValid;
    end
  end
  // Sticky events; a new event beats a same-cycle write-one clear.
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] clr;
  assign evt = {armPulse && !cfgValid, trigReg};
  assign clr = (wbWr && wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0])
               ? wb_dat_i[IRQ_W-1:0] : '0;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStatReg <= '0;
    end else begin
      irqStatReg <= (irqStatReg & ~clr) | evt;
    end
  end
  assign irq = |(irqStatReg & irqMaskReg);
  // Read mux, captured as the ack is raised; unmapped reads give zero.
  logic [31:0] rdMux;
  always_comb begin
    rdMux = RST_WORD;
    if (stageHit) begin
      rdMux = cfgSel ? cfgMem[stageIdx] : condMem[stageIdx];
    end else begin
      unique case (wb_adr_i)
        OFS_DEPTH:    rdMux[DW-1:0] = depthReg;
        OFS_STATUS: begin
          rdMux[ST_RUN]         = stateReg == SQ_RUN;
          rdMux[ST_DONE]        = stateReg == SQ_DONE;
          rdMux[ST_ERR]         = errReg;
          rdMux[ST_PTR +: PW]   = ptrReg;
        end
        OFS_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStatReg;
        OFS_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMaskReg;
        default:      rdMux = RST_WORD;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      datReg <= RST_WORD;
    end else if (wbReq && !ackReg) begin
      datReg <= rdMux;
    end
  end
  assign wb_dat_o = datReg;
  // Checks on the sequencer and the bus slave.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_depth_reject: assert property (
    armPulse && depthReg > MAXD |=> stateReg == SQ_IDLE && errReg)
    else $error("over-deep expression was armed");
  chk_next_window: assert property (
    stateReg == SQ_RUN && immEntry && !cond && !armPulse && !disarmPulse
    |=> ptrReg == '0 && cntReg == '0)
    else $error("failed immediate stage did not restart");
  chk_then_advance: assert property (
    hit && !lastStage && !armPulse && !disarmPulse
    |=> ptrReg == $past(ptrReg) + PW'(1) && firstReg && cntReg == '0)
    else $error("stage completion did not advance pointer");
  chk_consec_break: assert property (
    stateReg == SQ_RUN && mode == CM_CONSEC && cntReg != '0 && !cond &&
    !armPulse && !disarmPulse |=> ptrReg == '0 && cntReg == '0)
    else $error("consecutive break did not restart");
  chk_count_hold: assert property (
    stateReg == SQ_RUN && mode == CM_ANY && !cond && !armPulse &&
    !disarmPulse |=> cntReg == $past(cntReg) && ptrReg == $past(ptrReg))
    else $error("any-order counter moved on a false cycle");
  chk_trig_pulse: assert property (
    trigger |-> stateReg == SQ_DONE ##1 !trigger)
    else $error("trigger not a single pulse in done");
  chk_arm_reject: assert property (
    armPulse && !cfgValid |=> stateReg == SQ_IDLE ##0 irqStatReg[IRQ_REJ])
    else $error("invalid expression not rejected");
  chk_trig_irq: assert property (
    trigger |=> irqStatReg[IRQ_TRIG])
    else $error("trigger did not set its status bit");
  chk_wb_ack: assert property (
    wbReq && !ackReg |=> ackReg ##1 !ackReg)
    else $error("ack not given one cycle after request");

  cov_trigger:  cover property (trigger);
  cov_reject:   cover property (armPulse && !cfgValid);
  cov_restart:  cover property (restart && ptrReg != '0);
  cov_delay:    cover property (hit && curCfg[CF_TRUE] && target > 2);
endmodule // tse_trigger_sequence_engine

// [test/tse_term_source.sv]
// Match term source standing in for the observed user design.
`timescale 1ns/100ps
module tse_term_source (
  // Clock and reset.
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // Observed match pattern from the bench.
  input  wire logic [tse_pkg::NUM_TERMS-1:0] obsTerms,
  // Match results towards the engine.
  output logic      [tse_pkg::NUM_TERMS-1:0] matchTerm
);
  import tse_pkg::*;
  // Terms are registered as a real comparator would be, so each pattern
  // word reaches the engine one sample clock after the bench drives it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      matchTerm <= '0;
    end else begin
      matchTerm <= obsTerms;
    end
  end
endmodule // tse_term_source

// [test/tb_trigger_sequence_engine.sv]
// Self-checking bench for the trigger sequence engine.
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_trigger_sequence_engine;
  import tse_pkg::*;
  // A small event limit keeps the oversize count case cheap.
  localparam int EVL = 100;
  logic        core_clk;
  logic        sys_rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [15:0] terms;
  logic [15:0] mt;
  logic        trigger;
  logic        irq;
  int          trigs;
  int          trigBase;
  int          cycles;
  int          checks;
  int          mismatches;
  // Grouping, order and negation cases: condition, pattern, triggers.
  logic [31:0] pc [7] = '{32'h60220100, 32'h60a28100, 32'h60a28100,
    32'h60600110, 32'h60600110, 32'h60604100, 32'h60604100};
  logic [15:0] ps [7] = '{16'h4, 16'h4, 16'h5, 16'h2, 16'h0, 16'h3, 16'h1};
  int          pe [7] = '{1, 0, 1, 1, 0, 0, 1};

  tse_trigger_sequence_engine #(.EVT_LIMIT(EVL))
    tse_trigger_sequence_engine_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .matchTerm(mt),
    .trigger(trigger), .irq(irq));
  tse_term_source tse_term_source_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .obsTerms(terms),
    .matchTerm(mt));

  // Free running sample clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Count trigger pulses, and cut a hung run short.
  always @(posedge core_clk) begin
    cycles++;
    if (trigger === 1'b1) begin
      trigs++;
    end
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  // Only the bench timeout ends a wait for an ack that never comes.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    `CHK(r & m, e)
  endtask

  task automatic stage(input int i, input logic [31:0] c,
                       input logic [31:0] f);
    wr(8'(OFS_STAGE + STAGE_STRIDE * i), c);
    wr(8'(OFS_STAGE + STAGE_STRIDE * i + OFS_CFG_SUB), f);
  endtask

  task automatic arm(input logic [31:0] d);
    wr(OFS_DEPTH, d);
    wr(OFS_CTRL, 32'h1);
    // The pulse counter has one writer; arming only notes its base.
    trigBase = trigs;
  endtask

  // One pattern word per sample clock, then the terms fall quiet.
  task automatic play(input logic [15:0] q[$]);
    foreach (q[i]) begin
      @(posedge core_clk);
      terms <= q[i];
    end
    @(posedge core_clk);
    terms <= 16'h0;
  endtask

  task automatic expt(input int w, input int n);
    repeat (w) @(posedge core_clk);
    `CHK(trigs - trigBase, n)
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Single term condition, other slots unused.
  function automatic logic [31:0] cond1(input logic [3:0] t);
    return {24'h606060, 4'h0, t};
  endfunction

  function automatic logic [31:0] cfg(input logic [15:0] n,
      input logic [1:0] m, input logic imm, input logic tru);
    return {12'h0, tru, imm, m, n};
  endfunction

  // Main sequence of scenarios.
  initial begin
    logic [15:0] q[$];
    sys_rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wdat = 32'h0;
    terms = 16'h0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(OFS_DEPTH, 32'h1f, 32'h1);
    rdc(OFS_STATUS, 32'hff, 32'h0);
    rdc(OFS_IRQ_MASK, 32'h3, 32'h0);
    wr(8'h30, 32'hffffffff);
    rdc(8'h30, 32'hffffffff, 32'h0);
    done("reset");
    stage(0, cond1(5), 32'h0);
    arm(32'h1);
    play('{16'h1, 16'h20, 16'h20});
    expt(4, 1);
    rdc(OFS_STATUS, 32'h3, 32'h2);
    rdc(OFS_IRQ_STAT, 32'h1, 32'h1);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h3);
    @(posedge core_clk);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h1);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    done("single");
    stage(0, cond1(0), 32'h0);
    stage(1, cond1(1), 32'h0);
    arm(32'h2);
    play('{16'h3});
    expt(4, 0);
    rdc(OFS_STATUS, 32'hf0, 32'h10);
    play('{16'h2});
    expt(4, 1);
    stage(1, cond1(1), cfg(16'd0, 2'd0, 1'b1, 1'b0));
    arm(32'h2);
    play('{16'h1, 16'h0, 16'h2});
    expt(4, 0);
    rdc(OFS_STATUS, 32'hf0, 32'h0);
    play('{16'h1, 16'h2});
    expt(4, 1);
    done("links");
    stage(0, cond1(0), cfg(16'd3, 2'd1, 1'b0, 1'b0));
    arm(32'h1);
    play('{16'h1, 16'h0, 16'h1});
    expt(4, 0);
    play('{16'h1});
    expt(4, 1);
    stage(0, cond1(0), 32'h0);
    stage(1, cond1(1), cfg(16'd3, 2'd2, 1'b1, 1'b0));
    arm(32'h2);
    play('{16'h1, 16'h2, 16'h0, 16'h2, 16'h2, 16'h2});
    expt(4, 0);
    play('{16'h1, 16'h2, 16'h2, 16'h2});
    expt(4, 1);
    stage(1, cond1(9), cfg(16'd8, 2'd1, 1'b0, 1'b1));
    arm(32'h2);
    play('{16'h1});
    expt(4, 0);
    expt(10, 1);
    done("counters");
    for (int k = 0; k < 7; k++) begin
      stage(0, pc[k], 32'h0);
      arm(32'h1);
      play('{ps[k]});
      expt(4, pe[k]);
    end
    done("precedence");
    // Rejected arms: too deep, any-order count on an immediate stage, bad mode,
    // and a target above the build-time limit.
    wr(OFS_IRQ_MASK, 32'h2);
    for (int k = 0; k < 4; k++) begin
      stage(0, cond1(0), k == 2 ? cfg(16'd0, 2'd3, 1'b0, 1'b0) :
            k == 3 ? cfg(16'(EVL + 1), 2'd1, 1'b0, 1'b0) : 32'h0);
      stage(1, cond1(1), k == 1 ? cfg(16'd0, 2'd1, 1'b1, 1'b0) : 32'h0);
      wr(OFS_IRQ_STAT, 32'h3);
      arm(k == 0 ? 32'd17 : k == 1 ? 32'h2 : 32'h1);
      rdc(OFS_STATUS, 32'h5, 32'h4);
      `CHK(irq, 1'b1)
      play('{16'h3, 16'h3, 16'h3});
      expt(4, 0);
      wr(OFS_IRQ_STAT, 32'h2);
      @(posedge core_clk);
      `CHK(irq, 1'b0)
    end
    done("reject");
    for (int i = 0; i < 16; i++) begin
      stage(i, cond1(4'(i)), 32'h0);
      q.push_back(16'(1 << i));
    end
    arm(32'd16);
    play(q);
    expt(4, 1);
    rdc(OFS_IRQ_STAT, 32'h1, 32'h1);
    done("depth");
    // Re-arm mid-run goes back to stage 0; disarm stops all progress.
    arm(32'h2);
    play('{16'h1});
    rdc(OFS_STATUS, 32'hf1, 32'h11);
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_STATUS, 32'hf1, 32'h01);
    play('{16'h1});
    wr(OFS_CTRL, 32'h2);
    rdc(OFS_STATUS, 32'hf3, 32'h10);
    play('{16'h2});
    expt(4, 0);
    done("disarm");
    stop_test();
  end
endmodule // tb_trigger_sequence_engine
